// ### logic/mihc_ctrl.v
/*
 * Management interrupt, auto halt and stop-grant sequencing.
 * Assumes the core reports instruction boundaries, halt execution, resume
 * execution, lock and write-buffer status on core_clk_i; pins are async.
 */
// How it works
// - Halt enters halt state, leaves on interrupts.
// - Stop request in halt issues stop-grant cycle.
// - Stop release returns to halt, new halt cycle.
// - Falling-edge, non-maskable, asynchronous management request.
// - One low clock suffices; long lows fine.
// - Ignores irq flag, boundary only, not locked.
// - Beats nonmaskable irq, unmasked during its handler.
// - Masked from recognition until resume completes.
// - One pending request served right after resume.
// - Active asserted after writes drain, before save.
// - Active held through final restore read.
// - Active always driven, even during hold.
// - Save downward from base+FFFFh, fetch base+8000h.
// - Resume reloads context, releases active, returns.
// - Only I/O and halt restart supported.
// - Request pin is sole entry to mode.
// - Entry at least 161, return 258 clocks.
// - Reset, purge, mgmt, nmi, irq, stop priority.
// - Stop-grant drives 0000 0010h, byte enables 1011.
// - Base resets to 30000h, handler 38000h.
`timescale 1ns/100ps
`include "mihc_defs.vh"

module mihc_ctrl (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire sys_mgmt_irq_n_i,
    input wire clock_stop_req_n_i,
    input wire nonmaskable_irq_i,
    input wire maskable_irq_i,
    input wire irq_enable_flag_i,
    input wire soft_reset_i,
    input wire cache_purge_req_i,
    input wire instr_boundary_i,
    input wire locked_seq_i,
    input wire wbuf_empty_i,
    input wire halt_exec_i,
    input wire resume_exec_i,
    input wire restart_ok_i,
    input wire cycle_ready_n_i,
    input wire base_load_i,
    input wire [31:0] base_value_i,
    output reg sys_mgmt_active_n_o,
    output reg special_cycle_o,
    output reg [31:0] special_addr_o,
    output reg [3:0] special_be_o,
    output reg halted_o,
    output reg stop_granted_o,
    output reg take_mgmt_o,
    output reg take_nmi_o,
    output reg take_irq_o,
    output reg [31:0] fetch_addr_o,
    output reg [31:0] save_top_o,
    output reg restart_bad_o
);

// ----------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------
localparam [8:0] ENTRY_CNT = `MIHC_ENTRY_CLKS;
localparam [8:0] RETURN_CNT = `MIHC_RETURN_CLKS;

// ----------------------------------------------------------------
// One-hot states
// ----------------------------------------------------------------
localparam [7:0] S_RUN = 8'h01;
localparam [7:0] S_DRAIN = 8'h02;
localparam [7:0] S_SAVE = 8'h04;
localparam [7:0] S_HANDLER = 8'h08;
localparam [7:0] S_RESTORE = 8'h10;
localparam [7:0] S_HALT = 8'h20;
localparam [7:0] S_SGCYC = 8'h40;
localparam [7:0] S_STOPG = 8'h80;

reg [7:0] state_reg;
reg [7:0] state_next;
reg [8:0] cnt_reg;
reg [8:0] cnt_next;
reg smi_prev_reg;
reg pending_reg;
reg masked_reg;
reg nmi_busy_reg;
reg [31:0] base_reg;
reg halt_cycle_req_reg;
wire smi_sync;
wire stop_sync;
wire nmi_sync;
wire irq_sync;
wire [2:0] async_in;
wire [2:0] async_out;
wire smi_fall;
wire boundary_ok;
wire take_smi;
wire take_nmi;
wire take_irq;
wire cycle_done;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
assign async_in = {clock_stop_req_n_i, ~nonmaskable_irq_i, ~maskable_irq_i};

// Request line gets its own two flops before edge detection
mihc_sync u_smi_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sys_mgmt_irq_n_i),
    .sync_o(smi_sync)
);

// Remaining pins, same structure
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
        mihc_sync u_sync (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .async_i(async_in[gi]),
            .sync_o(async_out[gi])
        );
    end
endgenerate

assign stop_sync = async_out[2];
assign nmi_sync = ~async_out[1];
assign irq_sync = ~async_out[0];

// ----------------------------------------------------------------
// Recognition and priority
// ----------------------------------------------------------------
// Edge seen on synchronised level; one low sample is enough
assign smi_fall = smi_prev_reg & ~smi_sync;
// Boundary only, never inside a locked sequence, flag ignored
assign boundary_ok = instr_boundary_i & ~locked_seq_i;
// Reset and purge outrank everything; mgmt before nmi before irq
assign take_smi = boundary_ok & pending_reg & ~masked_reg & ~cache_purge_req_i
    & ~soft_reset_i;
assign take_nmi = boundary_ok & nmi_sync & ~nmi_busy_reg & ~take_smi
    & ~masked_reg & ~cache_purge_req_i & ~soft_reset_i;
assign take_irq = boundary_ok & irq_sync & irq_enable_flag_i & ~take_smi
    & ~take_nmi & ~masked_reg & ~cache_purge_req_i & ~soft_reset_i;
assign cycle_done = ~cycle_ready_n_i;

// ----------------------------------------------------------------
// State machine next state
// ----------------------------------------------------------------
always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
        S_RUN: begin
            if (take_smi) begin
                state_next = S_DRAIN;
            end else if (halt_exec_i) begin
                state_next = S_HALT;
            end
        end
        S_DRAIN: begin
            // Active only once write buffer has drained
            if (wbuf_empty_i) begin
                state_next = S_SAVE;
                cnt_next = ENTRY_CNT - 9'h001;
            end
        end
        S_SAVE: begin
            // Entry latency floor before handler fetch
            if (cnt_reg == 9'h000) begin
                state_next = S_HANDLER;
            end else begin
                cnt_next = cnt_reg - 9'h001;
            end
        end
        S_HANDLER: begin
            if (resume_exec_i) begin
                state_next = S_RESTORE;
                cnt_next = RETURN_CNT - 9'h001;
            end
        end
        S_RESTORE: begin
            // Active held until last restore read has gone
            if (cnt_reg == 9'h000) begin
                state_next = S_RUN;
            end else begin
                cnt_next = cnt_reg - 9'h001;
            end
        end
        S_HALT: begin
            // Wake on interrupts; stop request defers to them
            if (pending_reg & ~masked_reg) begin
                state_next = S_DRAIN;
            end else if (nmi_sync | (irq_sync & irq_enable_flag_i)) begin
                state_next = S_RUN;
            end else if (~stop_sync & ~halt_cycle_req_reg) begin
                state_next = S_SGCYC;
            end
        end
        S_SGCYC: begin
            if (cycle_done) begin
                state_next = S_STOPG;
            end
        end
        S_STOPG: begin
            if (stop_sync) begin
                state_next = S_HALT;
            end
        end
        default: begin
            state_next = S_RUN;
        end
    endcase
end

// ----------------------------------------------------------------
// State, counter, soft reset
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state_reg <= S_RUN;
        cnt_reg <= 9'h000;
    end else if (soft_reset_i) begin
        state_reg <= S_RUN;
        cnt_reg <= 9'h000;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
    end
end

// ----------------------------------------------------------------
// Edge detect, pending latch, masks
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        smi_prev_reg <= 1'b1;
        pending_reg <= 1'b0;
        masked_reg <= 1'b0;
        nmi_busy_reg <= 1'b0;
    end else begin
        smi_prev_reg <= smi_sync;
        // Only one request held; a new edge wins over consumption
        if (smi_fall) begin
            pending_reg <= 1'b1;
        end else if (state_reg == S_DRAIN && state_next == S_SAVE) begin
            pending_reg <= 1'b0;
        end
        // Mask from recognition until the restore finishes
        if (state_next == S_DRAIN && state_reg != S_DRAIN) begin
            masked_reg <= 1'b1;
        end else if (state_reg == S_RESTORE && state_next == S_RUN) begin
            masked_reg <= 1'b0;
        end
        // Nonmaskable handler in flight; management stays open
        if (take_nmi) begin
            nmi_busy_reg <= 1'b1;
        end else if (resume_exec_i && state_reg == S_RUN) begin
            nmi_busy_reg <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Base register
// ----------------------------------------------------------------
// Hard reset default; soft reset keeps it
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        base_reg <= `MIHC_BASE_RESET;
    end else if (base_load_i && state_reg == S_HANDLER && resume_exec_i) begin
        base_reg <= base_value_i;
    end
end

// ----------------------------------------------------------------
// Halt cycle request bookkeeping
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        halt_cycle_req_reg <= 1'b0;
    end else if (state_next == S_HALT && state_reg != S_HALT) begin
        halt_cycle_req_reg <= 1'b1;
    end else if (cycle_done) begin
        // Any ready retires it, even if a wake or soft reset left halt first
        halt_cycle_req_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        sys_mgmt_active_n_o <= 1'b1;
        special_cycle_o <= 1'b0;
        special_addr_o <= `MIHC_HALT_ADDR;
        special_be_o <= `MIHC_HALT_BE;
        halted_o <= 1'b0;
        stop_granted_o <= 1'b0;
        take_mgmt_o <= 1'b0;
        take_nmi_o <= 1'b0;
        take_irq_o <= 1'b0;
        fetch_addr_o <= 32'h0000_0000;
        save_top_o <= 32'h0000_0000;
        restart_bad_o <= 1'b0;
    end else begin
        // Always driven, hold has no effect on it
        sys_mgmt_active_n_o <= ~(state_next == S_SAVE || state_next == S_HANDLER
            || state_next == S_RESTORE);
        // Halt cycle on entry to halt, stop-grant cycle on entry to S_SGCYC
        if (state_next == S_SGCYC) begin
            special_cycle_o <= 1'b1;
            special_addr_o <= `MIHC_STOPG_ADDR;
            special_be_o <= `MIHC_STOPG_BE;
        end else if (state_next == S_HALT && halt_cycle_req_reg == 1'b0
                     && state_reg != S_HALT) begin
            special_cycle_o <= 1'b1;
            special_addr_o <= `MIHC_HALT_ADDR;
            special_be_o <= `MIHC_HALT_BE;
        end else if (cycle_done) begin
            special_cycle_o <= 1'b0;
        end
        halted_o <= (state_next == S_HALT);
        stop_granted_o <= (state_next == S_STOPG);
        take_mgmt_o <= (state_reg == S_RUN && take_smi) ||
            (state_reg == S_HALT && state_next == S_DRAIN);
        take_nmi_o <= take_nmi;
        take_irq_o <= take_irq;
        // Handler entry and save area derive from the base
        fetch_addr_o <= base_reg + `MIHC_HANDLER_OFS;
        save_top_o <= base_reg + `MIHC_SAVE_TOP_OFS;
        // Only I/O or halt opcodes may be restarted
        restart_bad_o <= (state_reg == S_HANDLER) & resume_exec_i
            & ~restart_ok_i;
    end
end

endmodule // mihc_ctrl

// ### inc/mihc_defs.vh
/*
 * Constants for the management interrupt and halt control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MIHC_DEFS_VH
`define MIHC_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define MIHC_CLK_MHZ 25
`define MIHC_ENTRY_CLKS 9'h0a1
`define MIHC_RETURN_CLKS 9'h102
`define MIHC_CNT_W 9
`define MIHC_REARM_CLKS 4

// ----------------------------------------------------------------
// Addresses and bus cycle codes
// ----------------------------------------------------------------
`define MIHC_BASE_RESET 32'h0003_0000
`define MIHC_HANDLER_OFS 32'h0000_8000
`define MIHC_SAVE_TOP_OFS 32'h0000_ffff
`define MIHC_HALT_ADDR 32'h0000_0000
`define MIHC_STOPG_ADDR 32'h0000_0010
`define MIHC_HALT_BE 4'hb
`define MIHC_STOPG_BE 4'hb

`endif

// ### logic/mihc_sync.v
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the destination clock is core_clk_i.
 */
`timescale 1ns/100ps
`include "mihc_defs.vh"

module mihc_sync (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire async_i,
    output reg sync_o
);

reg meta_reg;

// Both stages preset high so an idle active-low line reads inactive
always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        meta_reg <= 1'b1;
        sync_o <= 1'b1;
    end else begin
        meta_reg <= async_i;
        sync_o <= meta_reg;
    end
end

endmodule // mihc_sync

// ### bench/mihc_ctrl_properties.sv
/* Port checker for mihc_ctrl, bound at the foot of this file.
   Assumes one clock core_clk_i and an async active-low rst_n_i. */
`timescale 1ns/100ps
module mihc_ctrl_properties (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire instr_boundary_i,
    input wire locked_seq_i,
    input wire wbuf_empty_i,
    input wire halt_exec_i,
    input wire resume_exec_i,
    input wire cycle_ready_n_i,
    input wire sys_mgmt_active_n_o,
    input wire special_cycle_o,
    input wire [31:0] special_addr_o,
    input wire [3:0] special_be_o,
    input wire stop_granted_o,
    input wire take_mgmt_o,
    input wire take_nmi_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    reg [9:0] ret_reg;
    // Clocks since the last resume, saturating
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ret_reg <= 10'h000;
        else if (resume_exec_i) ret_reg <= 10'h000;
        else if (ret_reg != 10'h3ff) ret_reg <= ret_reg + 10'h001;
    end
    sequence s_halt_cyc;
        special_cycle_o && special_addr_o == 32'h0000_0000;
    endsequence
    sequence s_enter;
        ##[1:100] !sys_mgmt_active_n_o;
    endsequence
    a_take_at_boundary: assert property (
        take_mgmt_o |-> $past(instr_boundary_i) && !$past(locked_seq_i)) else $error("bad take");
    a_mgmt_over_nmi: assert property (
        take_mgmt_o |-> !take_nmi_o) else $error("nmi beat mgmt");
    a_masked_in_mode: assert property (
        !sys_mgmt_active_n_o |-> !take_mgmt_o) else $error("take while masked");
    a_active_after_drain: assert property (
        $fell(sys_mgmt_active_n_o) |-> $past(wbuf_empty_i)) else $error("active before drain");
    a_take_then_active: assert property (
        $rose(take_mgmt_o) |-> s_enter) else $error("no active after take");
    a_return_time: assert property (
        $rose(sys_mgmt_active_n_o) |-> ret_reg >= 10'd257) else $error("return too fast");
    a_stopg_addr: assert property (
        $rose(stop_granted_o) |-> $past(special_addr_o) == 32'h0000_0010) else $error("grant addr");
    a_special_be: assert property (
        special_cycle_o |-> special_be_o == 4'hb) else $error("byte enables");
    a_cycle_held: assert property (
        special_cycle_o && cycle_ready_n_i |=> special_cycle_o) else $error("cycle dropped");
    a_halt_regrant: assert property (
        $fell(stop_granted_o) |-> ##[0:4] s_halt_cyc) else $error("no new halt cycle");
    a_halt_cycle: assert property (
        halt_exec_i |-> ##[1:2] s_halt_cyc) else $error("no halt cycle");
endmodule // mihc_ctrl_properties

bind mihc_ctrl mihc_ctrl_properties mihc_ctrl_properties_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_boundary_i(instr_boundary_i),
    .locked_seq_i(locked_seq_i), .wbuf_empty_i(wbuf_empty_i), .halt_exec_i(halt_exec_i),
    .resume_exec_i(resume_exec_i), .cycle_ready_n_i(cycle_ready_n_i),
    .sys_mgmt_active_n_o(sys_mgmt_active_n_o), .special_cycle_o(special_cycle_o),
    .special_addr_o(special_addr_o), .special_be_o(special_be_o),
    .stop_granted_o(stop_granted_o), .take_mgmt_o(take_mgmt_o), .take_nmi_o(take_nmi_o));

// ### bench/mihc_chipset.sv
/* Chipset model: drives the management request and special cycle ready.
   Assumes it shares core_clk_i with the controller. */
`timescale 1ns/100ps
module mihc_chipset (
    input wire core_clk_i,
    input wire special_cycle_i,
    input wire [3:0] ready_dly_i,
    output reg sys_mgmt_irq_n_o,
    output reg cycle_ready_n_o
);
    initial begin
        sys_mgmt_irq_n_o = 1'b1;
        cycle_ready_n_o = 1'b1;
    end
    // Request low for w clocks, then high long enough to rearm
    task fire(input integer w);
        begin
            @(posedge core_clk_i);
            #1 sys_mgmt_irq_n_o = 1'b0;
            repeat (w) @(posedge core_clk_i);
            #1 sys_mgmt_irq_n_o = 1'b1;
            repeat (4) @(posedge core_clk_i);
        end
    endtask
    // Acknowledge each special cycle once, after a delay
    always @(posedge core_clk_i) begin
        if (special_cycle_i === 1'b1) begin
            repeat (ready_dly_i) @(posedge core_clk_i);
            #1 cycle_ready_n_o = 1'b0;
            @(posedge core_clk_i);
            #1 cycle_ready_n_o = 1'b1;
            while (special_cycle_i === 1'b1) @(posedge core_clk_i);
        end
    end
endmodule // mihc_chipset

// ### bench/mihc_ctrl_tb.sv
/* Self-checking bench for mihc_ctrl with a chipset model.
   Assumes the checker binds itself onto mihc_ctrl. */
`timescale 1ns/100ps
module mihc_ctrl_tb;
    reg core_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg stp_n = 1'b1, nmi = 1'b0, bnd = 1'b1, lck = 1'b0, wbe = 1'b0;
    reg hlt = 1'b0, resume_instr = 1'b0, rok = 1'b1;
    reg irq = 1'b0, ien = 1'b0, srst = 1'b0, purge = 1'b0, bload = 1'b0;
    reg [31:0] bval = 32'h0000_0000;
    reg [3:0] dly = 4'h1;
    wire irq_n, rdy_n, act_n, spc, hltd, sg, tm, tn, ti, bad;
    wire [31:0] sa, fa, st;
    wire [3:0] be;
    integer fails = 0, checks_done = 0, takes = 0, nt = 0, nb = 0, exp_takes = 0, i;
    integer ni = 0;
    reg spc_q = 1'b0;
    reg [31:0] exp_q [$];
    always #20 core_clk_i = ~core_clk_i;
    mihc_chipset mihc_chipset_i (.core_clk_i(core_clk_i), .special_cycle_i(spc),
        .ready_dly_i(dly), .sys_mgmt_irq_n_o(irq_n), .cycle_ready_n_o(rdy_n));
    mihc_ctrl mihc_ctrl_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .sys_mgmt_irq_n_i(irq_n), .clock_stop_req_n_i(stp_n), .nonmaskable_irq_i(nmi),
        .maskable_irq_i(irq), .irq_enable_flag_i(ien), .soft_reset_i(srst),
        .cache_purge_req_i(purge), .instr_boundary_i(bnd), .locked_seq_i(lck),
        .wbuf_empty_i(wbe), .halt_exec_i(hlt), .resume_exec_i(resume_instr), .restart_ok_i(rok),
        .cycle_ready_n_i(rdy_n), .base_load_i(bload), .base_value_i(bval),
        .sys_mgmt_active_n_o(act_n), .special_cycle_o(spc), .special_addr_o(sa),
        .special_be_o(be), .halted_o(hltd), .stop_granted_o(sg), .take_mgmt_o(tm),
        .take_nmi_o(tn), .take_irq_o(ti), .fetch_addr_o(fa), .save_top_o(st),
        .restart_bad_o(bad));
    task summarize;
        begin
            $display("fails %0d checks_done %0d", fails, checks_done);
            if (fails == 0 && checks_done > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
            end
        end
    endtask
    task tk(input integer k);
        begin
            repeat (k) @(posedge core_clk_i);
            #1;
        end
    endtask
    // Reference model: count pulses, compare each new special cycle
    always @(posedge core_clk_i) begin
        #1;
        if (tm === 1'b1) takes = takes + 1;
        if (tn === 1'b1) nt = nt + 1;
        if (ti === 1'b1) ni = ni + 1;
        if (bad === 1'b1) nb = nb + 1;
        if (spc === 1'b1 && spc_q !== 1'b1 && exp_q.size() > 0) chk(exp_q.pop_front(), sa);
        spc_q = spc;
    end
    function logic sel(input integer w);
        case (w)
            0: sel = takes >= exp_takes;
            1: sel = !act_n;
            3: sel = sg;
            4: sel = hltd;
            6: sel = ni > 0;
            default: sel = nt > 0;
        endcase
    endfunction
    // Bounded wait for a condition
    task await(input integer w, input integer lim);
        integer n;
        begin
            n = 0;
            while (sel(w) !== 1'b1 && n < lim) begin
                tk(1);
                n = n + 1;
            end
            chk(1, n < lim);
            if (n >= lim) summarize();
        end
    endtask
    // Run a handler, resume, time the return
    task ret(input reg na);
        integer n;
        begin
            await(1, 100);
            tk(200);
            resume_instr = 1'b1;
            tk(1);
            resume_instr = 1'b0;
            nmi = na;
            n = 1;
            while (act_n !== 1'b1 && n < 400) begin
                tk(1);
                n = n + 1;
            end
            chk(1, n >= 258 && n < 400);
        end
    endtask
    initial begin
        i = $urandom(51626);
        tk(3);
        rst_n_i = 1'b1;
        tk(2);
        chk(1, act_n);
        chk(4'hb, be);
        chk(32'h0003_8000, fa);
        chk(32'h0003_ffff, st);
        lck = 1'b1;
        exp_takes = 1;
        mihc_chipset_i.fire(1);
        tk(6);
        chk(0, takes);
        lck = 1'b0;
        bnd = 1'b0;
        tk(3);
        chk(0, takes);
        bnd = 1'b1;
        await(0, 20);
        tk(5);
        chk(1, act_n);
        wbe = 1'b1;
        await(1, 100);
        mihc_chipset_i.fire(1 + $urandom % 6);
        mihc_chipset_i.fire(2);
        exp_takes = 2;
        ret(1'b1);
        await(0, 20);
        chk(0, nt);
        ret(1'b1);
        await(5, 20);
        nmi = 1'b0;
        exp_takes = 3;
        mihc_chipset_i.fire(1);
        await(0, 20);
        rok = 1'b0;
        ret(1'b0);
        rok = 1'b1;
        chk(1, nb);
        dly = $urandom % 4;
        exp_q.push_back(32'h0000_0000);
        hlt = 1'b1;
        tk(1);
        hlt = 1'b0;
        await(4, 10);
        tk(8);
        exp_q.push_back(32'h0000_0010);
        exp_q.push_back(32'h0000_0000);
        stp_n = 1'b0;
        await(3, 30);
        stp_n = 1'b1;
        tk(12);
        chk(0, sg);
        chk(1, hltd);
        exp_takes = 4;
        mihc_chipset_i.fire(1);
        await(0, 20);
        tk(2);
        chk(0, hltd);
        ret(1'b0);
        // Purge held over a new request blocks it; then relocate the base
        purge = 1'b1;
        exp_takes = 5;
        mihc_chipset_i.fire(1);
        tk(4);
        chk(4, takes);
        purge = 1'b0;
        await(0, 20);
        bval = ($urandom % 16) << 16;
        bload = 1'b1;
        ret(1'b0);
        bload = 1'b0;
        tk(2);
        chk(bval + 32'h0000_8000, fa);
        chk(bval + 32'h0000_ffff, st);
        // Maskable request waits for its flag, then wakes a halted core
        irq = 1'b1;
        tk(6);
        chk(0, ni);
        ien = 1'b1;
        await(6, 20);
        irq = 1'b0;
        tk(4);
        exp_q.push_back(32'h0000_0000);
        hlt = 1'b1;
        tk(1);
        hlt = 1'b0;
        await(4, 10);
        irq = 1'b1;
        tk(5);
        chk(0, hltd);
        irq = 1'b0;
        ien = 1'b0;
        tk(6);
        // Soft reset leaves halt and keeps the relocated base
        exp_q.push_back(32'h0000_0000);
        hlt = 1'b1;
        tk(1);
        hlt = 1'b0;
        await(4, 10);
        srst = 1'b1;
        tk(1);
        srst = 1'b0;
        tk(1);
        chk(0, hltd);
        chk(bval + 32'h0000_8000, fa);
        tk(8);
        chk(exp_takes, takes);
        chk(0, exp_q.size());
        summarize();
    end
endmodule // mihc_ctrl_tb
